// ### design/uart_sfc_regs.svh
// Offsets, field positions, encodings and reset values for the in-band flow control block.
// Assumes a 32-bit classic Wishbone bus with byte addresses on an 8-bit address.
`ifndef UART_SFC_REGS_SVH
`define UART_SFC_REGS_SVH
// Register byte offsets
`define OFF_FLAG_STATUS 8'h18
`define OFF_IRQ_MASK 8'h38
`define OFF_RAW_IRQ 8'h3C
`define OFF_MASKED_IRQ 8'h40
`define OFF_IRQ_CLEAR 8'h44
`define OFF_SOFT_FLOW_CTRL 8'h50
`define OFF_RESUME_CHAR_A 8'h54
`define OFF_RESUME_CHAR_B 8'h58
`define OFF_PAUSE_CHAR_A 8'h5C
`define OFF_PAUSE_CHAR_B 8'h60
// Flow mode encodings, shared by receive and transmit fields
`define MODE_OFF 2'b00
`define MODE_SET_A 2'b01
`define MODE_SET_B 2'b10
`define MODE_BOTH 2'b11
// Interrupt source bit positions
`define IRQ_TX_EMPTY 0
`define IRQ_PAUSE 1
`define IRQ_RX 2
`define IRQ_TX 3
`define IRQ_TIMEOUT 4
`define IRQ_ERROR 5
// Field widths and reset values
`define CFG_W 7
`define IRQ_W 6
`define CFG_RESET 7'h00
`define CHAR_RESET 8'h00
`define MASK_RESET 6'h00
`endif

// ### design/uart_sfc_pkg.sv
// Types shared by the flow control block and its receive matcher helper.
// Assumes uart_sfc_regs.svh holds the matching widths.
package uart_sfc_pkg;
	typedef struct packed {logic valid; logic [7:0] data;} char_t;
	typedef struct packed {
		logic cyc; logic stb; logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat;
	} wb_req_t;
	typedef struct packed {logic ack; logic [31:0] dat;} wb_rsp_t;
	typedef struct packed {
		logic special_char_detect_en;
		logic resume_on_any_char;
		logic [1:0] tx_soft_flow_mode;
		logic [1:0] rx_soft_flow_mode;
		logic soft_flow_enable;
	} flow_cfg_t;
	typedef struct packed {logic error; logic timeout; logic tx; logic rx;} irq_evt_t;
	typedef logic [5:0] level_t;
	typedef enum logic [1:0] {
		INS_IDLE = 2'b00,
		INS_PAUSE = 2'b01,
		INS_RESUME = 2'b10
	} ins_state_t;
endpackage

// ### design/rx_flow_match.sv
// Receive side matcher: pause, resume and special character hits, and the store decision.
// Assumes one received character per valid pulse, on the same clock as the caller.
`timescale 1ns/10ps
`include "uart_sfc_regs.svh"
module rx_flow_match (
	input wire logic clk_i,
	input wire logic rst_i,
	input uart_sfc_pkg::char_t rx_i,
	input uart_sfc_pkg::flow_cfg_t cfg_i,
	input wire logic [7:0] pause_char_a_i,
	input wire logic [7:0] pause_char_b_i,
	input wire logic [7:0] resume_char_a_i,
	input wire logic [7:0] resume_char_b_i,
	input wire logic suspended_i,
	output logic pause_hit_o,
	output logic resume_hit_o,
	output logic special_hit_o,
	output logic store_o
);
	logic rx_on;
	logic prev_a;
	logic pause_match;
	logic resume_match;
	logic any_take;

	// First half of a two-character pause, cleared by any following character other than pause A
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			prev_a <= 1'b0;
		else if (rx_i.valid)
			prev_a <= (rx_i.data == pause_char_a_i);
	end

	// Error status of the character is deliberately not looked at
	always_comb
	begin
		rx_on = cfg_i.soft_flow_enable && !cfg_i.special_char_detect_en
			&& (cfg_i.rx_soft_flow_mode != `MODE_OFF);
		pause_match = 1'b0;
		resume_match = 1'b0;
		unique case (cfg_i.rx_soft_flow_mode)
			`MODE_OFF: pause_match = 1'b0;
			`MODE_SET_A:
			begin
				pause_match = (rx_i.data == pause_char_a_i);
				resume_match = (rx_i.data == resume_char_a_i);
			end
			`MODE_SET_B:
			begin
				pause_match = (rx_i.data == pause_char_b_i);
				resume_match = (rx_i.data == resume_char_b_i);
			end
			`MODE_BOTH:
			begin
				pause_match = prev_a && (rx_i.data == pause_char_b_i);
				resume_match = (rx_i.data == resume_char_a_i) || (rx_i.data == resume_char_b_i);
			end
		endcase
		any_take = suspended_i && cfg_i.resume_on_any_char;
		pause_hit_o = rx_i.valid && rx_on && pause_match;
		resume_hit_o = rx_i.valid && rx_on && suspended_i && (any_take || resume_match);
		special_hit_o = rx_i.valid && cfg_i.special_char_detect_en
			&& (rx_i.data == pause_char_b_i);
		store_o = rx_i.valid && !(rx_on && (pause_match || (resume_match && !any_take)));
	end
endmodule

// ### design/irq_combiner.sv
// Sticky raw interrupt flags, mask gating and the single interrupt output.
// Assumes set and clear vectors are one-cycle pulses on the same clock.
`timescale 1ns/10ps
`include "uart_sfc_regs.svh"
module irq_combiner (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [`IRQ_W-1:0] set_i,
	input wire logic [`IRQ_W-1:0] clr_i,
	input wire logic [`IRQ_W-1:0] mask_i,
	output logic [`IRQ_W-1:0] raw_o,
	output logic [`IRQ_W-1:0] masked_o,
	output logic irq_o
);
	// Set wins over clear so an event landing on a clear write is kept
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			raw_o <= '0;
		else
			raw_o <= (raw_o & ~clr_i) | set_i;
	end

	assign masked_o = raw_o & mask_i;

	// Registered so the pin never glitches while flags and mask change together
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |masked_o;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_irq_follows_mask: assert property (|masked_o |=> irq_o)
		else $error("irq output missed a masked flag");
	a_clear_pause_flag: assert property (clr_i[`IRQ_PAUSE] && !set_i[`IRQ_PAUSE]
		|=> !raw_o[`IRQ_PAUSE])
		else $error("pause flag survived a clear");
	a_set_beats_clear: assert property (set_i[`IRQ_PAUSE] |=> raw_o[`IRQ_PAUSE])
		else $error("pause event lost");
endmodule

// ### design/uart_soft_flow_and_irq.sv
// In-band flow control and interrupt combining for one serial port, with a Wishbone slave.
// Assumes receiver, transmitter and FIFOs run on clk_i; tx_ready_i falls the cycle after
// tx_char_o is valid and stays low until the last stop bit has left the shift register.
//
// Overview of operation
// - Global enable low switches off both receive and transmit flow control.
// - Receive mode: off, set A, set B, or both sets.
// - Both-sets receive mode needs pause A then pause B back to back.
// - Transmit mode: off, set A, set B, or both sets.
// - Pause match halts transmit after the current character and sets pause flag.
// - While halted a resume match clears pause flag and lets transmit resume.
// - Resume-on-any: any character resumes and is stored; a pause match while halted instead keeps the halt and is not stored.
// - Matched pause and resume characters are not stored, with stated exceptions.
// - Matches ignore parity, framing and break errors.
// - Receive fill above trigger inserts pause and sets remote disabled flag.
// - Fill below trigger inserts resume and clears remote disabled flag.
// - Turning flow off after a pause inserts resume and clears the flag.
// - Inserted characters are framed like ordinary transmit data.
// - Special detect forces flow off; pause B sets flag, stored, no halt.
// - Writing one to the pause clear bit clears the pause flag.
// - Six maskable sources merge onto one interrupt output.
// - Mask one enables; raw readable always; masked is raw AND mask.
// - Transmit-empty flag sets when busy falls.
// - Busy stays up until the last stop bit has left.
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "uart_sfc_regs.svh"
module uart_soft_flow_and_irq (
	input wire logic clk_i,
	input wire logic rst_i,
	input uart_sfc_pkg::wb_req_t wb_req_i,
	output uart_sfc_pkg::wb_rsp_t wb_rsp_o,
	input uart_sfc_pkg::char_t rx_char_i,
	output uart_sfc_pkg::char_t rx_store_o,
	input uart_sfc_pkg::level_t rx_fill_i,
	input uart_sfc_pkg::level_t rx_trigger_level_i,
	input wire logic txf_valid_i,
	input wire logic [7:0] txf_data_i,
	output logic txf_pop_o,
	input wire logic tx_ready_i,
	output uart_sfc_pkg::char_t tx_char_o,
	input uart_sfc_pkg::irq_evt_t irq_evt_i,
	output logic irq_o
);
	uart_sfc_pkg::flow_cfg_t cfg;
	uart_sfc_pkg::ins_state_t ins_state;
	logic [7:0] pause_char_a;
	logic [7:0] pause_char_b;
	logic [7:0] resume_char_a;
	logic [7:0] resume_char_b;
	logic [`IRQ_W-1:0] irq_mask;
	logic [`IRQ_W-1:0] raw_irq_status;
	logic [`IRQ_W-1:0] masked_irq_status;
	logic [`IRQ_W-1:0] irq_set;
	logic [`IRQ_W-1:0] irq_clr;
	logic [`IRQ_W-1:0] icr_clr;
	logic remote_tx_disabled;
	logic suspended;
	logic pause_hit;
	logic resume_hit;
	logic special_hit;
	logic store;
	logic access;
	logic wr;
	logic tx_on;
	logic can_start;
	logic busy;
	logic busy_q;
	logic tx_empty_evt;
	logic [1:0] ins_set;
	logic ins_second;
	logic next_send;
	logic next_pop;
	logic next_last;
	logic [7:0] next_char;
	logic [31:0] next_rdata;

	// Address match on the word, used for every register
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		hit = (adr[7:2] == off[7:2]);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave

	// A new request is one not yet acknowledged; ack drops for a cycle between requests
	assign access = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
	assign wr = access && wb_req_i.we && wb_req_i.sel[0];

	// Acknowledge and read data one cycle after the request appears
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_rsp_o <= '0;
		else
		begin
			wb_rsp_o.ack <= access;
			wb_rsp_o.dat <= access ? next_rdata : 32'h0000_0000;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (hit(wb_req_i.adr, `OFF_SOFT_FLOW_CTRL))
			next_rdata[`CFG_W-1:0] = cfg;
		else if (hit(wb_req_i.adr, `OFF_RESUME_CHAR_A))
			next_rdata[7:0] = resume_char_a;
		else if (hit(wb_req_i.adr, `OFF_RESUME_CHAR_B))
			next_rdata[7:0] = resume_char_b;
		else if (hit(wb_req_i.adr, `OFF_PAUSE_CHAR_A))
			next_rdata[7:0] = pause_char_a;
		else if (hit(wb_req_i.adr, `OFF_PAUSE_CHAR_B))
			next_rdata[7:0] = pause_char_b;
		else if (hit(wb_req_i.adr, `OFF_FLAG_STATUS))
			next_rdata[1:0] = {busy_q, remote_tx_disabled};
		else if (hit(wb_req_i.adr, `OFF_IRQ_MASK))
			next_rdata[`IRQ_W-1:0] = irq_mask;
		else if (hit(wb_req_i.adr, `OFF_RAW_IRQ))
			next_rdata[`IRQ_W-1:0] = raw_irq_status;
		else if (hit(wb_req_i.adr, `OFF_MASKED_IRQ))
			next_rdata[`IRQ_W-1:0] = masked_irq_status;
	end

	// Configuration and character registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg <= `CFG_RESET;
			pause_char_a <= `CHAR_RESET;
			pause_char_b <= `CHAR_RESET;
			resume_char_a <= `CHAR_RESET;
			resume_char_b <= `CHAR_RESET;
			irq_mask <= `MASK_RESET;
		end
		else if (wr)
		begin
			if (hit(wb_req_i.adr, `OFF_SOFT_FLOW_CTRL))
				cfg <= wb_req_i.dat[`CFG_W-1:0];
			if (hit(wb_req_i.adr, `OFF_RESUME_CHAR_A))
				resume_char_a <= wb_req_i.dat[7:0];
			if (hit(wb_req_i.adr, `OFF_RESUME_CHAR_B))
				resume_char_b <= wb_req_i.dat[7:0];
			if (hit(wb_req_i.adr, `OFF_PAUSE_CHAR_A))
				pause_char_a <= wb_req_i.dat[7:0];
			if (hit(wb_req_i.adr, `OFF_PAUSE_CHAR_B))
				pause_char_b <= wb_req_i.dat[7:0];
			if (hit(wb_req_i.adr, `OFF_IRQ_MASK))
				irq_mask <= wb_req_i.dat[`IRQ_W-1:0];
		end
	end

	// Clear pulses: write one to a bit of the clear register
	assign icr_clr = (wr && hit(wb_req_i.adr, `OFF_IRQ_CLEAR)) ?
		wb_req_i.dat[`IRQ_W-1:0] : '0;

	////////////////////////////////////////////////////////////////////////////////
	// Receive side

	rx_flow_match u_match (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rx_i(rx_char_i),
		.cfg_i(cfg),
		.pause_char_a_i(pause_char_a),
		.pause_char_b_i(pause_char_b),
		.resume_char_a_i(resume_char_a),
		.resume_char_b_i(resume_char_b),
		.suspended_i(suspended),
		.pause_hit_o(pause_hit),
		.resume_hit_o(resume_hit),
		.special_hit_o(special_hit),
		.store_o(store)
	);

	// Halt state; also dropped when the global enable is cleared or special detect is set, so the port cannot lock
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			suspended <= 1'b0;
		else if (pause_hit)
			suspended <= 1'b1;
		else if (resume_hit || !cfg.soft_flow_enable || cfg.special_char_detect_en)
			suspended <= 1'b0;
	end

	// Characters passed on to the receive FIFO
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rx_store_o <= '0;
		else
		begin
			rx_store_o.valid <= store;
			rx_store_o.data <= rx_char_i.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit side

	assign tx_on = cfg.soft_flow_enable && !cfg.special_char_detect_en
		&& (cfg.tx_soft_flow_mode != `MODE_OFF);
	assign can_start = tx_ready_i && !tx_char_o.valid;

	// Inserted characters first, FIFO data only when not halted
	always_comb
	begin
		next_send = 1'b0;
		next_pop = 1'b0;
		next_char = txf_data_i;
		next_last = (ins_second || (ins_set != `MODE_BOTH));
		if (can_start && (ins_state != uart_sfc_pkg::INS_IDLE))
		begin
			next_send = 1'b1;
			if (ins_state == uart_sfc_pkg::INS_PAUSE)
				next_char = ins_second ? pause_char_b : pause_char_a;
			else
				next_char = ins_second ? resume_char_b : resume_char_a;
		end
		else if (can_start && !suspended && txf_valid_i)
		begin
			next_send = 1'b1;
			next_pop = 1'b1;
		end
	end

	// One character path to the framer, so inserted ones get the programmed format
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_char_o <= '0;
			txf_pop_o <= 1'b0;
		end
		else
		begin
			tx_char_o.valid <= next_send;
			tx_char_o.data <= next_char;
			txf_pop_o <= next_pop;
		end
	end

	// Insertion sequencer; the set in use is kept so a later resume matches the pause
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ins_state <= uart_sfc_pkg::INS_IDLE;
			ins_set <= `MODE_OFF;
			ins_second <= 1'b0;
		end
		else
		begin
			unique case (ins_state)
				uart_sfc_pkg::INS_IDLE:
					if (tx_on && !remote_tx_disabled && (rx_fill_i > rx_trigger_level_i))
					begin
						ins_state <= uart_sfc_pkg::INS_PAUSE;
						ins_set <= cfg.tx_soft_flow_mode;
						ins_second <= (cfg.tx_soft_flow_mode == `MODE_SET_B);
					end
					else if (remote_tx_disabled && (!tx_on || (rx_fill_i < rx_trigger_level_i)))
					begin
						ins_state <= uart_sfc_pkg::INS_RESUME;
						ins_second <= (ins_set == `MODE_SET_B);
					end
				uart_sfc_pkg::INS_PAUSE, uart_sfc_pkg::INS_RESUME:
					if (next_send && next_last)
						ins_state <= uart_sfc_pkg::INS_IDLE;
					else if (next_send)
						ins_second <= 1'b1;
				default: ins_state <= uart_sfc_pkg::INS_IDLE;
			endcase
		end
	end

	// Flag changes as the last inserted character is handed to the framer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			remote_tx_disabled <= 1'b0;
		else if (next_send && next_last && (ins_state == uart_sfc_pkg::INS_PAUSE))
			remote_tx_disabled <= 1'b1;
		else if (next_send && next_last && (ins_state == uart_sfc_pkg::INS_RESUME))
			remote_tx_disabled <= 1'b0;
	end

	// Busy while anything is queued, being handed over, or still shifting out
	assign busy = txf_valid_i || !tx_ready_i || tx_char_o.valid;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			busy_q <= 1'b0;
		else
			busy_q <= busy;
	end
	assign tx_empty_evt = busy_q && !busy;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts

	assign irq_set = {irq_evt_i.error, irq_evt_i.timeout, irq_evt_i.tx, irq_evt_i.rx,
		pause_hit || special_hit, tx_empty_evt};
	assign irq_clr = icr_clr | {{(`IRQ_W-2){1'b0}}, resume_hit, 1'b0};

	irq_combiner u_irq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(irq_set),
		.clr_i(irq_clr),
		.mask_i(irq_mask),
		.raw_o(raw_irq_status),
		.masked_o(masked_irq_status),
		.irq_o(irq_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_bus_ack_once: assert property (access |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
		else $error("ack not a single cycle after request");
	a_flow_off_quiet: assert property (!cfg.soft_flow_enable |-> !pause_hit && !resume_hit)
		else $error("flow match while disabled");
	a_pause_halts_fifo: assert property (pause_hit |=> suspended ##1 !txf_pop_o)
		else $error("fifo drained after pause");
	a_resume_clears_flag: assert property (resume_hit && !pause_hit && !special_hit
		|=> !raw_irq_status[`IRQ_PAUSE] && !suspended)
		else $error("resume left pause state");
	a_match_not_stored: assert property (pause_hit |=> !rx_store_o.valid)
		else $error("pause char stored");
	a_special_kept: assert property (special_hit |=> rx_store_o.valid
		&& raw_irq_status[`IRQ_PAUSE] && !suspended)
		else $error("special char mishandled");
	a_pause_sent_flag: assert property ($rose(remote_tx_disabled) |-> tx_char_o.valid
		&& (tx_char_o.data == pause_char_a || tx_char_o.data == pause_char_b))
		else $error("remote disabled without pause char");
	a_insert_first: assert property (can_start && ins_state != uart_sfc_pkg::INS_IDLE
		|=> tx_char_o.valid && !txf_pop_o)
		else $error("fifo data beat inserted char");
	a_tx_empty_flag: assert property (tx_empty_evt |=> raw_irq_status[`IRQ_TX_EMPTY])
		else $error("tx empty flag missed");
	c_pause_resume: cover property (pause_hit ##[1:200] resume_hit);
	c_special: cover property (special_hit);
	c_insert_pause: cover property ($rose(remote_tx_disabled) ##[1:500] $fell(remote_tx_disabled));
endmodule

// ### tb/tx_line_model.sv
// Stand-in for the framer and serial line behind the transmit start port.
// Assumes one-cycle start pulses on clk_i; every frame lasts FRAME_CYCLES cycles.
`timescale 1ns/10ps
module tx_line_model #(
	parameter int FRAME_CYCLES = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input uart_sfc_pkg::char_t tx_char_i,
	output logic tx_ready_o,
	output logic [7:0] sent_count_o
);
	int left;
	////////////////////////////////////////////////////////////////////////////
	// Same frame length for data and inserted characters, busy to last stop bit
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_ready_o <= 1'b1;
			left <= 0;
			sent_count_o <= 8'h00;
		end
		else if (tx_char_i.valid)
		begin
			tx_ready_o <= 1'b0;
			left <= FRAME_CYCLES;
			sent_count_o <= sent_count_o + 8'h01;
		end
		else if (left > 1)
			left <= left - 1;
		else if (left == 1)
		begin
			tx_ready_o <= 1'b1;
			left <= 0;
		end
	end
endmodule

// ### tb/tb.sv
// Self-checking bench for the in-band flow control and interrupt block.
// Assumes the register offsets of uart_sfc_regs.svh and a 16-cycle frame model.
`timescale 1ns/10ps
`include "uart_sfc_regs.svh"
module tb;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	uart_sfc_pkg::wb_req_t req = '0;
	uart_sfc_pkg::wb_rsp_t rsp;
	uart_sfc_pkg::char_t rxc = '0;
	uart_sfc_pkg::char_t store;
	uart_sfc_pkg::char_t txc;
	uart_sfc_pkg::level_t fill = 6'h00;
	uart_sfc_pkg::level_t trig = 6'h08;
	uart_sfc_pkg::irq_evt_t evt = '0;
	logic txf_valid = 1'b0;
	logic [7:0] txf_data = 8'h00;
	logic pop, ready, irq;
	logic [7:0] sent;
	logic [31:0] d;
	int miscompares = 0;
	int checked = 0;
	row_t rows[11] = '{
		'{8'h54, 32'h0000_0011, 32'h0000_0011}, '{8'h58, 32'h0000_0013, 32'h0000_0013},
		'{8'h5C, 32'h0000_0091, 32'h0000_0091}, '{8'h60, 32'h0000_0093, 32'h0000_0093},
		'{8'h50, 32'h0000_007F, 32'h0000_007F}, '{8'h50, 32'h0000_0000, 32'h0000_0000},
		'{8'h38, 32'h0000_002A, 32'h0000_002A}, '{8'h38, 32'h0000_0000, 32'h0000_0000},
		'{8'h70, 32'h0000_00FF, 32'h0000_0000}, '{8'h44, 32'h0000_0000, 32'h0000_0000},
		'{8'h18, 32'h0000_0003, 32'h0000_0000}};
	always #10 clk = ~clk;
	uart_soft_flow_and_irq uut (.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_rsp_o(rsp),
		.rx_char_i(rxc), .rx_store_o(store), .rx_fill_i(fill), .rx_trigger_level_i(trig),
		.txf_valid_i(txf_valid), .txf_data_i(txf_data), .txf_pop_o(pop), .tx_ready_i(ready),
		.tx_char_o(txc), .irq_evt_i(evt), .irq_o(irq));
	tx_line_model line (.clk_i(clk), .rst_i(rst), .tx_char_i(txc), .tx_ready_o(ready),
		.sent_count_o(sent));
	////////////////////////////////////////////////////////////////////////////
	// Verdict in one place, reached by the main sequence and by any timeout
	task report_and_stop;
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// One classic cycle; ack and read data are taken at the rising edge that sees ack high
	task wb(input logic we, input logic [7:0] a, input logic [31:0] w);
		int k;
		k = 0;
		@(posedge clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: w};
		@(posedge clk);
		while (rsp.ack !== 1'b1 && k < 50)
		begin
			@(posedge clk);
			k++;
		end
		if (k == 50)
		begin
			miscompares++;
			report_and_stop();
		end
		d = rsp.dat;
		req <= '0;
	endtask
	task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk("register", d & m, e);
	endtask
	// One received character; the store decision shows one cycle after it is taken
	task rx(input logic [7:0] c, input logic st);
		@(posedge clk);
		rxc <= '{valid: 1'b1, data: c};
		@(posedge clk);
		rxc <= '0;
		@(negedge clk);
		chk("store valid", 32'(store.valid), 32'(st));
		if (st)
			chk("store data", 32'(store.data), 32'(c));
	endtask
	// Waits for the next start pulse, bounded, and checks its character and pop
	task txw(input logic [7:0] e, input logic p);
		int k;
		k = 0;
		while (txc.valid !== 1'b1 && k < 300)
		begin
			@(negedge clk);
			k++;
		end
		if (k == 300)
		begin
			miscompares++;
			report_and_stop();
		end
		chk("tx char", 32'(txc.data), 32'(e));
		chk("tx pop", 32'(pop), 32'(p));
		@(posedge clk);
		if (p)
			txf_valid <= 1'b0;
		@(negedge clk);
	endtask
	task cfg(input logic [31:0] v);
		wb(1'b1, `OFF_SOFT_FLOW_CTRL, v);
		wb(1'b1, `OFF_IRQ_CLEAR, 32'h0000_003F);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i])
			rdm(rows[i].a, 32'hFFFF_FFFF, 32'h0000_0000);
		foreach (rows[i])
		begin
			wb(1'b1, rows[i].a, rows[i].w);
			rdm(rows[i].a, 32'hFFFF_FFFF, rows[i].e);
		end
		// Pause from set A halts FIFO data until the resume character arrives
		cfg(32'h0000_0003);
		rx(8'h91, 1'b0);
		rdm(`OFF_RAW_IRQ, 32'h0000_0002, 32'h0000_0002);
		txf_data <= 8'h41;
		txf_valid <= 1'b1;
		repeat (20) @(posedge clk);
		chk("halted", 32'(sent), 32'h0000_0000);
		rx(8'h55, 1'b1);
		rx(8'h11, 1'b0);
		txw(8'h41, 1'b1);
		rdm(`OFF_RAW_IRQ, 32'h0000_0002, 32'h0000_0000);
		// Global enable off, receive mode off, set B, then both sets back to back
		cfg(32'h0000_0002);
		rx(8'h91, 1'b1);
		cfg(32'h0000_0001);
		rx(8'h91, 1'b1);
		rdm(`OFF_RAW_IRQ, 32'h0000_0002, 32'h0000_0000);
		cfg(32'h0000_0005);
		rx(8'h93, 1'b0);
		rx(8'h13, 1'b0);
		rdm(`OFF_RAW_IRQ, 32'h0000_0002, 32'h0000_0000);
		cfg(32'h0000_0007);
		rx(8'h93, 1'b1);
		rdm(`OFF_RAW_IRQ, 32'h0000_0002, 32'h0000_0000);
		@(posedge clk);
		rxc <= '{valid: 1'b1, data: 8'h91};
		@(posedge clk);
		rxc <= '{valid: 1'b1, data: 8'h93};
		@(negedge clk);
		chk("first of pair", 32'(store.valid), 32'h0000_0001);
		@(posedge clk);
		rxc <= '0;
		@(negedge clk);
		chk("second of pair", 32'(store.valid), 32'h0000_0000);
		rdm(`OFF_RAW_IRQ, 32'h0000_0002, 32'h0000_0002);
		rx(8'h13, 1'b0);
		rdm(`OFF_RAW_IRQ, 32'h0000_0002, 32'h0000_0000);
		// Resume on any character stores it
		cfg(32'h0000_0023);
		rx(8'h91, 1'b0);
		rx(8'h5A, 1'b1);
		rdm(`OFF_RAW_IRQ, 32'h0000_0002, 32'h0000_0000);
		// Special detect: pause B flagged and stored, no halt, then write-one clear
		cfg(32'h0000_0043);
		rx(8'h93, 1'b1);
		rx(8'h91, 1'b1);
		rdm(`OFF_RAW_IRQ, 32'h0000_0002, 32'h0000_0002);
		txf_data <= 8'h42;
		txf_valid <= 1'b1;
		txw(8'h42, 1'b1);
		wb(1'b1, `OFF_IRQ_CLEAR, 32'h0000_0002);
		rdm(`OFF_RAW_IRQ, 32'h0000_0002, 32'h0000_0000);
		// Inserted characters by fill level, ahead of queued data, at the boundary
		cfg(32'h0000_0009);
		fill <= 6'h08;
		repeat (20) @(posedge clk);
		chk("no insert at trigger", 32'(sent), 32'h0000_0002);
		fill <= 6'h09;
		// Data is queued only once the insert is pending, so both compete for one slot
		@(posedge clk);
		txf_data <= 8'h43;
		txf_valid <= 1'b1;
		txw(8'h91, 1'b0);
		rdm(`OFF_FLAG_STATUS, 32'h0000_0001, 32'h0000_0001);
		txw(8'h43, 1'b1);
		@(posedge clk);
		fill <= 6'h07;
		txw(8'h11, 1'b0);
		rdm(`OFF_FLAG_STATUS, 32'h0000_0001, 32'h0000_0000);
		cfg(32'h0000_0011);
		fill <= 6'h09;
		txw(8'h93, 1'b0);
		cfg(32'h0000_0000);
		txw(8'h13, 1'b0);
		rdm(`OFF_FLAG_STATUS, 32'h0000_0001, 32'h0000_0000);
		cfg(32'h0000_0019);
		txw(8'h91, 1'b0);
		txw(8'h93, 1'b0);
		cfg(32'h0000_0000);
		txw(8'h11, 1'b0);
		txw(8'h13, 1'b0);
		// Transmit empty only once the whole frame is out
		repeat (30) @(posedge clk);
		txf_data <= 8'h44;
		txf_valid <= 1'b1;
		txw(8'h44, 1'b1);
		wb(1'b1, `OFF_IRQ_CLEAR, 32'h0000_003F);
		rdm(`OFF_RAW_IRQ, 32'h0000_0001, 32'h0000_0000);
		repeat (20) @(posedge clk);
		rdm(`OFF_RAW_IRQ, 32'h0000_0001, 32'h0000_0001);
		// Masking and merging of the event sources onto one output
		wb(1'b1, `OFF_IRQ_CLEAR, 32'h0000_003F);
		wb(1'b1, `OFF_IRQ_MASK, 32'h0000_0004);
		@(posedge clk);
		evt <= '{error: 1'b1, timeout: 1'b1, tx: 1'b1, rx: 1'b0};
		@(posedge clk);
		evt <= '0;
		repeat (3) @(negedge clk);
		chk("irq masked out", 32'(irq), 32'h0000_0000);
		rdm(`OFF_RAW_IRQ, 32'h0000_003C, 32'h0000_0038);
		@(posedge clk);
		evt <= '{error: 1'b0, timeout: 1'b0, tx: 1'b0, rx: 1'b1};
		@(posedge clk);
		evt <= '0;
		repeat (3) @(negedge clk);
		chk("irq", 32'(irq), 32'h0000_0001);
		rdm(`OFF_MASKED_IRQ, 32'h0000_003F, 32'h0000_0004);
		wb(1'b1, `OFF_IRQ_CLEAR, 32'h0000_003F);
		repeat (3) @(negedge clk);
		chk("irq cleared", 32'(irq), 32'h0000_0000);
		report_and_stop();
	end
endmodule
